//--- hw/beat_term_regs.svh
// Constants for the data beat termination link.
// Assumes inclusion by both ends and the package; definitions only.
`ifndef BEAT_TERM_REGS_SVH
`define BEAT_TERM_REGS_SVH
`define DATA_W 64
`define BURST_BEATS 3'h4
`define SINGLE_BEATS 3'h1
`define BEAT_CNT_W 3
`define LAST_BURST_IDX 2'h3
`endif

//--- hw/beat_term_pkg.sv
// Types shared by both ends of the data beat termination link.
// Assumes beat_term_regs.svh sits on the include path.
`include "beat_term_regs.svh"
package beat_term_pkg;
    typedef logic [`DATA_W-1:0] data_t;
    typedef enum logic [3:0] {
        DEV_IDLE = 4'h1,
        DEV_BEAT = 4'h2,
        DEV_RETRY = 4'h4,
        DEV_STOP = 4'h8
    } dev_state_e;
    typedef enum logic [2:0] {
        HOST_IDLE = 3'h1,
        HOST_ACK = 3'h2,
        HOST_RETRY = 3'h4
    } host_state_e;
endpackage

//--- hw/beat_term_if.sv
// Link between the bus master (device end) and the memory controller.
// Assumes one clock shared by both ends; data bus busy is modelled per driver.
`timescale 1ns/1ps
interface beat_term_if;
    logic data_bus_busy_o;
    logic data_bus_busy_oe;
    logic data_bus_busy;
    logic address_ack;
    logic transfer_ack;
    logic data_retry;
    logic transfer_error_ack;
    logic is_write;
    logic is_burst;
    logic [63:0] wdata;
    logic [63:0] rdata;
    // Wire level: high-active busy resolved from enable, released means idle
    assign data_bus_busy = data_bus_busy_oe & data_bus_busy_o;
    modport dev (
        output data_bus_busy_o,
        output data_bus_busy_oe,
        output is_write,
        output is_burst,
        output wdata,
        input address_ack,
        input transfer_ack,
        input data_retry,
        input transfer_error_ack,
        input rdata
    );
    modport sys (
        input data_bus_busy,
        input is_write,
        input is_burst,
        input wdata,
        output address_ack,
        output transfer_ack,
        output data_retry,
        output transfer_error_ack,
        output rdata
    );
endinterface

//--- hw/beat_term_dev.sv
// Device end: owns the data tenure and terminates beats on acknowledges.
// Assumes the system end drives the link inputs from flops on clk_sys.
// Assumes start is raised only while busy is low.
`timescale 1ns/1ps
module beat_term_dev
    import beat_term_pkg::*;
(
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic start,
    input wire logic start_write,
    input wire logic start_burst,
    input wire data_t start_wdata,
    input wire logic machine_check_enable,
    output logic busy,
    output data_t beat_rdata,
    output logic beat_valid,
    output logic beat_discard,
    output logic [1:0] beat_idx,
    output logic done,
    output logic machine_check,
    output logic checkstop,
    beat_term_if.dev link
);
    // Terminations arrive from the system end on this same clock.
    // A synchroniser here would let the system acknowledge the next beat
    // before this end had advanced, so the link inputs are read directly.
    wire address_ack_s = link.address_ack;
    wire ta_s = link.transfer_ack;
    wire dr_s = link.data_retry;
    wire tea_s = link.transfer_error_ack;
    wire data_t rdata_s = link.rdata;

    dev_state_e state_q, state_d;
    logic write_q;
    logic burst_q;
    logic [`BEAT_CNT_W-1:0] left_q;
    logic [1:0] idx_q;
    data_t wdata_q;
    data_t rdata_q;
    logic stop_q;

    // Terminations only count while the tenure is ours
    wire own = (state_q == DEV_BEAT) | (state_q == DEV_RETRY);
    wire err = own & tea_s;
    wire ack = (state_q == DEV_BEAT) & ta_s & ~tea_s;
    wire last_beat = (left_q == `SINGLE_BEATS);
    wire retry_hit = (state_q == DEV_RETRY) & ~write_q & dr_s & ~tea_s;
    wire retry_clear = (state_q == DEV_RETRY) & ~dr_s & ~tea_s;

    // Beat sequencing
    always_comb begin
        state_d = state_q;
        case (state_q)
            DEV_IDLE: begin
                if (start && !stop_q) begin
                    state_d = DEV_BEAT;
                end
            end
            DEV_BEAT: begin
                if (err) begin
                    state_d = DEV_IDLE;
                end else if (ack && !write_q) begin
                    state_d = DEV_RETRY;
                end else if (ack && last_beat) begin
                    state_d = DEV_IDLE;
                end
            end
            DEV_RETRY: begin
                if (err) begin
                    state_d = DEV_IDLE;
                end else if (dr_s) begin
                    state_d = DEV_BEAT; // beat is re-run
                end else if (last_beat) begin
                    state_d = DEV_IDLE;
                end else begin
                    state_d = DEV_BEAT;
                end
            end
            DEV_STOP: begin
                state_d = DEV_STOP;
            end
            default: begin
                state_d = DEV_IDLE;
            end
        endcase
    end

    // Machine check or checkstop on error
    wire stop_now = err & ~machine_check_enable;
    // Beat outcomes seen this cycle
    wire beat_ok = retry_clear | (ack & write_q);
    wire tenure_end = (beat_ok & last_beat) | err;

    // State register; checkstop overrides the next state
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            state_q <= DEV_IDLE;
        end else if (stop_now) begin
            state_q <= DEV_STOP;
        end else begin
            state_q <= state_d;
        end
    end

    // Beat bookkeeping strobes
    wire load = (state_q == DEV_IDLE) & start;
    wire advance = (ack & write_q) | retry_clear;

    // Transfer set-up and beat counting
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            write_q <= 1'b0;
            burst_q <= 1'b0;
            left_q <= '0;
            idx_q <= 2'h0;
            wdata_q <= '0;
        end else if (load) begin
            write_q <= start_write;
            burst_q <= start_burst;
            left_q <= start_burst ? `BURST_BEATS : `SINGLE_BEATS;
            idx_q <= 2'h0;
            wdata_q <= start_wdata;
        end else if (advance) begin
            left_q <= left_q - `BEAT_CNT_W'(1);
            idx_q <= idx_q + 2'h1;
            wdata_q <= ~wdata_q; // next beat pattern, held until ack
        end
    end

    // Speculative capture of read data with its acknowledge
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            rdata_q <= '0;
        end else if (ack) begin
            rdata_q <= rdata_s; // speculative capture
        end
    end

    // Read data handed on only once the retry window has passed
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            beat_rdata <= '0;
        end else if (retry_clear) begin
            beat_rdata <= rdata_q; // never rolled back
        end
    end

    // One-cycle beat result pulses
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            beat_valid <= 1'b0;
            beat_discard <= 1'b0;
            beat_idx <= 2'h0;
            done <= 1'b0;
        end else begin
            beat_valid <= beat_ok;
            beat_discard <= retry_hit;
            beat_idx <= idx_q;
            done <= tenure_end;
        end
    end

    // Error reporting: machine check pulse or sticky checkstop
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            machine_check <= 1'b0;
            stop_q <= 1'b0;
        end else begin
            machine_check <= err & machine_check_enable;
            stop_q <= stop_q | stop_now;
        end
    end

    // Busy driven only in the tenure; released with the error
    assign link.data_bus_busy_o = own;
    assign link.data_bus_busy_oe = own;
    assign link.is_write = write_q;
    assign link.is_burst = burst_q;
    assign link.wdata = wdata_q;
    // Local status
    assign busy = (state_q != DEV_IDLE);
    assign checkstop = stop_q;
    wire unused_address_ack = address_ack_s;
endmodule

//--- hw/beat_term_sys.sv
// System end: memory controller terminating each beat.
// Assumes the device end drives its link outputs from flops on clk_sys.
`timescale 1ns/1ps
module beat_term_sys
    import beat_term_pkg::*;
(
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic mem_ready,
    input wire logic mem_bad,
    input wire logic mem_error,
    input wire data_t mem_rdata,
    output data_t wr_data,
    output logic wr_strobe,
    beat_term_if.sys link
);
    host_state_e state_q;
    logic ta_q;
    logic dr_q;
    logic tea_q;
    logic address_ack_q;
    data_t rdata_q;
    logic [`BEAT_CNT_W-1:0] beats_q;

    // Busy comes from the device end on this clock: read directly
    wire busy_s = link.data_bus_busy;
    wire retry_now = ~link.is_write & mem_bad;
    wire [`BEAT_CNT_W-1:0] need = link.is_burst ? `BURST_BEATS : `SINGLE_BEATS;
    wire more = (beats_q < need);

    // Beats acknowledged without retry in this tenure
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            beats_q <= '0;
        end else if (!busy_s) begin
            beats_q <= '0;
        end else if (state_q == HOST_ACK && !retry_now) begin
            beats_q <= beats_q + `BEAT_CNT_W'(1);
        end
    end

    // One-cycle acknowledge per beat, retry right after a bad read
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            state_q <= HOST_IDLE;
            ta_q <= 1'b0;
            dr_q <= 1'b0;
            tea_q <= 1'b0;
            address_ack_q <= 1'b0;
            rdata_q <= '0;
            wr_data <= '0;
            wr_strobe <= 1'b0;
        end else begin
            ta_q <= 1'b0;
            wr_strobe <= 1'b0;
            tea_q <= busy_s & mem_error;
            address_ack_q <= busy_s;
            case (state_q)
                HOST_IDLE: begin
                    dr_q <= 1'b0;
                    if (busy_s && address_ack_q && mem_ready && more && !tea_q) begin
                        ta_q <= 1'b1;
                        rdata_q <= mem_rdata;
                        wr_data <= link.wdata;
                        wr_strobe <= link.is_write;
                        state_q <= HOST_ACK;
                    end
                end
                HOST_ACK: begin
                    dr_q <= ~link.is_write & mem_bad;
                    state_q <= (~link.is_write & mem_bad) ? HOST_RETRY : HOST_IDLE;
                end
                HOST_RETRY: begin
                    if (!mem_bad) begin
                        dr_q <= 1'b0;
                        rdata_q <= mem_rdata;
                        state_q <= HOST_IDLE;
                    end
                end
                default: begin
                    state_q <= HOST_IDLE;
                end
            endcase
        end
    end

    assign link.transfer_ack = ta_q;
    assign link.data_retry = dr_q;
    assign link.transfer_error_ack = tea_q;
    assign link.address_ack = address_ack_q;
    assign link.rdata = rdata_q;
endmodule

//--- testbench/beat_term_chk.sv
// Checker for the wires of the beat termination link.
// Assumes one clock domain; sees only the link signals.
`timescale 1ns/1ps
module beat_term_chk (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic data_bus_busy,
    input wire logic data_bus_busy_oe,
    input wire logic address_ack,
    input wire logic transfer_ack,
    input wire logic data_retry,
    input wire logic transfer_error_ack,
    input wire logic is_write,
    input wire logic is_burst,
    input wire logic [63:0] wdata
);
    logic address_ack_q;
    logic err_q;
    logic [2:0] acks_q;
    logic [3:0] idle_q;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);
    // Per-tenure bookkeeping, cleared while the bus is free
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            address_ack_q <= 1'b0;
            err_q <= 1'b0;
            acks_q <= 3'h0;
        end else begin
            address_ack_q <= data_bus_busy & (address_ack_q | address_ack);
            err_q <= data_bus_busy & (err_q | transfer_error_ack);
            acks_q <= data_bus_busy ? acks_q + {2'h0, transfer_ack} : 3'h0;
        end
    end
    // Cycles since the last termination, saturating
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) idle_q <= 4'hF;
        else idle_q <= (transfer_ack | transfer_error_ack) ? 4'h0 : idle_q + {3'h0, idle_q != 4'hF};
    end
    AST_ACK_PULSE: assert property (transfer_ack |=> !transfer_ack) else $error("ack held");
    AST_ACK_AFTER_ADDRESS_ACK: assert property (transfer_ack |-> address_ack_q) else $error("early ack");
    AST_RETRY_AFTER_ACK: assert property ($rose(data_retry) |-> $past(transfer_ack)) else $error("late retry");
    AST_BUSY_END: assert property ($fell(data_bus_busy) |-> idle_q < 4'h7) else $error("busy end");
    AST_ERR_RELEASE: assert property (transfer_error_ack && data_bus_busy |-> ##[1:5] !data_bus_busy_oe)
        else $error("busy kept after error");
    AST_ERR_CLEAR: assert property ($fell(data_bus_busy) |-> !transfer_error_ack) else $error("error held");
    AST_BEAT_COUNT: assert property ($fell(data_bus_busy) && $past(is_write) && !err_q
        |-> acks_q == ($past(is_burst) ? 3'h4 : 3'h1)) else $error("beat count");
    AST_WDATA_HOLD: assert property (data_bus_busy && $past(data_bus_busy) && is_write && $changed(wdata)
        |-> $past(transfer_ack))
        else $error("write data moved");
endmodule

//--- testbench/data_beat_termination_tb.sv
// Self-checking bench for both ends of the beat termination link.
// Assumes a 200 MHz clk_sys shared by both ends and the checker.
`timescale 1ns/1ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin n_mismatch++; \
    $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module data_beat_termination_tb;
    import beat_term_pkg::*;
    localparam data_t W = 64'h0123_4567_89AB_CDEF;
    localparam data_t R = 64'hFEDC_BA98_7654_3210;
    localparam data_t R2 = 64'h55AA_33CC_0FF0_A5A5;
    logic clk_sys = 1'b0;
    logic arst_n = 1'b0;
    logic start = 1'b0;
    logic start_write = 1'b0;
    logic start_burst = 1'b0;
    logic machine_check_enable = 1'b1;
    logic mem_ready = 1'b1;
    logic mem_bad = 1'b0;
    logic mem_error = 1'b0;
    data_t start_wdata = '0;
    data_t mem_rdata = R;
    data_t beat_rdata, wr_data;
    logic busy, beat_valid, beat_discard, done, machine_check, checkstop, wr_strobe;
    int n_mismatch, total_checks, n_wr, n_val, n_disc, n_mc, n_done, cyc;
    beat_term_if link ();
    beat_term_dev u_beat_term_dev (.clk_sys(clk_sys), .arst_n(arst_n), .start(start), .start_write(start_write),
        .start_burst(start_burst), .start_wdata(start_wdata), .machine_check_enable(machine_check_enable),
        .busy(busy), .beat_rdata(beat_rdata), .beat_valid(beat_valid), .beat_discard(beat_discard), .beat_idx(),
        .done(done), .machine_check(machine_check), .checkstop(checkstop), .link(link.dev));
    beat_term_sys u_beat_term_sys (.clk_sys(clk_sys), .arst_n(arst_n), .mem_ready(mem_ready), .mem_bad(mem_bad),
        .mem_error(mem_error), .mem_rdata(mem_rdata), .wr_data(wr_data), .wr_strobe(wr_strobe), .link(link.sys));
    beat_term_chk u_beat_term_chk (.clk_sys(clk_sys), .arst_n(arst_n), .data_bus_busy(link.data_bus_busy),
        .data_bus_busy_oe(link.data_bus_busy_oe), .address_ack(link.address_ack), .transfer_ack(link.transfer_ack),
        .data_retry(link.data_retry), .transfer_error_ack(link.transfer_error_ack), .is_write(link.is_write),
        .is_burst(link.is_burst), .wdata(link.wdata));
    always #2.5 clk_sys = ~clk_sys;
    // Pulse counters and the run ceiling
    always @(negedge clk_sys) begin
        n_wr += (wr_strobe === 1'b1);
        n_val += (beat_valid === 1'b1);
        n_disc += (beat_discard === 1'b1);
        n_mc += (machine_check === 1'b1);
        n_done += (done === 1'b1);
        cyc++;
        if (cyc == 6000) begin
            n_mismatch++;
            final_report();
        end
    end
    // One transfer from start until the bus is free again
    task automatic run(input logic wr, input logic bur, input data_t wd);
        n_wr = 0; n_val = 0; n_disc = 0; n_mc = 0; n_done = 0;
        @(posedge clk_sys); #1;
        start = 1'b1; start_write = wr; start_burst = bur; start_wdata = wd;
        @(posedge clk_sys); #1;
        start = 1'b0;
        for (int i = 0; i < 400 && busy !== 1'b0; i++) @(posedge clk_sys);
        repeat (8) @(posedge clk_sys);
        #1;
    endtask
    task automatic t_write_single();
        run(1'b1, 1'b0, W);
        `CHK(n_wr, 1)
        `CHK(wr_data, W)
    endtask
    // Burst write held in wait states, then released
    task automatic t_write_stall();
        mem_ready = 1'b0;
        fork begin
            repeat (20) @(posedge clk_sys);
            #1;
            `CHK(busy, 1'b1)
            `CHK(n_wr, 0)
            mem_ready = 1'b1;
        end join_none
        run(1'b1, 1'b1, W);
        `CHK(n_wr, 4)
        `CHK(wr_data, ~W)
    endtask
    task automatic t_read_burst();
        run(1'b0, 1'b1, W);
        `CHK(n_val, 4)
        `CHK(beat_rdata, R)
        `CHK(n_disc, 0)
    endtask
    // Read retried while the data source is bad
    task automatic t_read_retry();
        mem_bad = 1'b1;
        fork begin
            repeat (14) @(posedge clk_sys);
            #1 mem_bad = 1'b0;
            mem_rdata = R2;
        end join_none
        run(1'b0, 1'b0, W);
        `CHK(n_disc != 0, 1'b1)
        `CHK(n_val, 1)
        `CHK(beat_rdata, R2)
    endtask
    task automatic t_write_bad();
        mem_bad = 1'b1;
        run(1'b1, 1'b0, W);
        mem_bad = 1'b0;
        `CHK(n_done, 1)
        `CHK(n_disc, 0)
    endtask
    // Error on a stalled burst read
    task automatic t_error(input logic mce);
        machine_check_enable = mce;
        mem_ready = 1'b0;
        fork begin
            repeat (10) @(posedge clk_sys);
            #1 mem_error = 1'b1;
            @(posedge clk_sys);
            #1 mem_error = 1'b0;
            mem_ready = 1'b1;
        end join_none
        run(1'b0, 1'b1, W);
        `CHK(n_mc, int'(mce))
        `CHK(checkstop, ~mce)
        `CHK(n_val, 0)
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge clk_sys);
        #1 arst_n = 1'b1;
        t_write_single();
        t_write_stall();
        t_read_burst();
        t_read_retry();
        t_write_bad();
        t_error(1'b1);
        t_error(1'b0);
        final_report();
    end
endmodule
